// ===== ddrct_top.sv
// Single-rank four-bank DDR DRAM device: command decode, banks and bursts
`timescale 1ns/10ps
// Function
// - Burst stop releases data pins after 3
// - Precharge ending read releases data after 3
// - Write data starts one cycle after command
// - Mask qualifies data on same strobe
// - Commands taken only with chip select low
// - Activate captures row from A0 to A12
// - Read or write captures column A0-A9
// - Precharge: A10 high means all banks
// - Read or write: A10 high auto-precharges
// - Bank select: BA0 low bit, BA1 high
// - Clock enable low enters, high exits
// - Commands sampled on rising clock edge
// - Strobe driven by device on reads
module ddrct_top
  import ddrct_pkg::*;
(
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET,
  // Command and address
  input  wire logic              CKE,
  input  wire logic              CS_N,
  input  wire logic              RAS_N,
  input  wire logic              CAS_N,
  input  wire logic              WE_N,
  input  wire logic [ROW_W-1:0]  A,
  input  wire logic [BANK_W-1:0] BA,
  // Data, two beats per clock, low beat first
  input  wire logic [PAIR_W-1:0] DQ_I,
  output logic      [PAIR_W-1:0] DQ_O,
  output logic                   DQ_OE,
  input  wire logic              DQS_I,
  output logic                   DQS_O,
  output logic                   DQS_OE,
  input  wire logic [1:0]        DM_I,
  // Status
  output logic                   POWER_DOWN,
  output logic                   SELF_REFRESH
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  ddrct_burst_if rd ();
  ddrct_burst_if wr ();

  ddrct_pwr_t           pwr_ff;
  ddrct_pwr_t           nxt_pwr;
  logic                 cke_ff;
  logic [3:0]           bl_ff;
  logic [NBANK-1:0]     open_ff;
  logic [ROW_W-1:0]     row_ff [NBANK];
  logic [PAIR_W-1:0]    mem_ff [MEM_DEPTH];
  logic [READ_LAT-2:0]  rvld_ff;
  logic [PAIR_W-1:0]    rdat_ff [READ_LAT-1];
  logic                 cmd_ok;
  logic [2:0]           cmd;
  logic                 is_act;
  logic                 is_rd;
  logic                 is_wr;
  logic                 is_pre;
  logic                 pre_all;
  logic                 rd_cut;
  logic [MEM_AW-1:0]    rd_addr;
  logic [MEM_AW-1:0]    wr_addr;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  assign cmd     = {RAS_N, CAS_N, WE_N};
  assign cmd_ok  = ~CS_N & CKE & cke_ff & (pwr_ff == PWR_ACTIVE);
  assign is_act  = cmd_ok & (cmd == CMD_ACT);
  assign is_pre  = cmd_ok & (cmd == CMD_PRE);
  assign pre_all = A[AP_BIT];
  assign is_rd   = cmd_ok & (cmd == CMD_RD) & open_ff[BA];
  assign is_wr   = cmd_ok & (cmd == CMD_WR) & open_ff[BA];

  // Precharge of the reading bank cuts the read short
  assign rd_cut  = is_pre & rd.active & (pre_all | (BA == rd.bank));

  // ----------------------------------------
  // Burst sequencers
  // ----------------------------------------
  assign rd.start   = is_rd;
  assign rd.stop    = (cmd_ok & (cmd == CMD_BST)) | rd_cut;
  assign rd.ap_in   = A[AP_BIT];
  assign rd.bank_in = BA;
  assign rd.col_in  = A[COL_W-1:0];
  assign rd.bl      = bl_ff;

  assign wr.start   = is_wr;
  assign wr.stop    = is_pre & wr.active & (pre_all | (BA == wr.bank));
  assign wr.ap_in   = A[AP_BIT];
  assign wr.bank_in = BA;
  assign wr.col_in  = A[COL_W-1:0];
  assign wr.bl      = bl_ff;

  ddrct_burst u_rd (
    .clk   (CLK),
    .reset (RESET),
    .bus   (rd.eng)
  );

  ddrct_burst u_wr (
    .clk   (CLK),
    .reset (RESET),
    .bus   (wr.eng)
  );

  assign rd_addr = {rd.bank, row_ff[rd.bank][ROW_KEEP-1:0], rd.col[4:1]};
  assign wr_addr = {wr.bank, row_ff[wr.bank][ROW_KEEP-1:0], wr.col[4:1]};

  // ----------------------------------------
  // Mode register
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      bl_ff <= BL_RESET;
    end else if (cmd_ok && cmd == CMD_MRS && BA == 2'h0) begin
      case (A[BL_MSB:BL_LSB])
        BL_CODE2: bl_ff <= 4'h2;
        BL_CODE4: bl_ff <= 4'h4;
        BL_CODE8: bl_ff <= 4'h8;
        default:  bl_ff <= bl_ff;
      endcase
    end
  end

  // ----------------------------------------
  // Bank state
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      open_ff <= '0;
    end else begin
      if (rd.fin && rd.ap) begin
        open_ff[rd.bank] <= 1'b0;
      end
      if (wr.fin && wr.ap) begin
        open_ff[wr.bank] <= 1'b0;
      end
      if (is_pre) begin
        if (pre_all) begin
          open_ff <= '0;
        end else begin
          open_ff[BA] <= 1'b0;
        end
      end
      if (is_act) begin
        open_ff[BA] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      for (int i = 0; i < NBANK; i++) begin
        row_ff[i] <= '0;
      end
    end else if (is_act) begin
      row_ff[BA] <= A;
    end
  end

  // ----------------------------------------
  // Write data path
  // ----------------------------------------
  // Engine becomes active the edge after the command, so data lands one cycle later
  always_ff @(posedge CLK) begin
    if (wr.active && DQS_I) begin
      for (int b = 0; b < 2; b++) begin
        if (!DM_I[b]) begin
          mem_ff[wr_addr][b*BEAT_W +: BEAT_W] <= DQ_I[b*BEAT_W +: BEAT_W];
        end
      end
    end
  end

  // ----------------------------------------
  // Read data path
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rvld_ff <= '0;
    end else begin
      rvld_ff <= {rvld_ff[READ_LAT-3:0], rd.active};
    end
  end

  always_ff @(posedge CLK) begin
    rdat_ff[0] <= mem_ff[rd_addr];
    for (int s = 1; s < READ_LAT - 1; s++) begin
      rdat_ff[s] <= rdat_ff[s-1];
    end
  end

  // Third stage drives the pins; a stop clears the source so pins float three edges later
  always_ff @(posedge CLK) begin
    if (RESET) begin
      DQ_O   <= '0;
      DQ_OE  <= 1'b0;
      DQS_O  <= 1'b0;
      DQS_OE <= 1'b0;
    end else begin
      DQ_O   <= rdat_ff[READ_LAT-2];
      DQ_OE  <= rvld_ff[READ_LAT-2];
      DQS_O  <= rvld_ff[READ_LAT-2];
      DQS_OE <= rvld_ff[READ_LAT-2];
    end
  end

  // ----------------------------------------
  // Power state
  // ----------------------------------------
  always_comb begin
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      PWR_ACTIVE: begin
        if (cke_ff && !CKE) begin
          if (!CS_N && cmd == CMD_REF) begin
            nxt_pwr = PWR_SELF;
          end else begin
            nxt_pwr = PWR_DOWN;
          end
        end
      end
      PWR_DOWN: begin
        if (CKE) begin
          nxt_pwr = PWR_ACTIVE;
        end
      end
      PWR_SELF: begin
        if (CKE) begin
          nxt_pwr = PWR_ACTIVE;
        end
      end
      default: nxt_pwr = PWR_ACTIVE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      pwr_ff <= PWR_ACTIVE;
      cke_ff <= 1'b1;
    end else begin
      pwr_ff <= nxt_pwr;
      cke_ff <= CKE;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      POWER_DOWN   <= 1'b0;
      SELF_REFRESH <= 1'b0;
    end else begin
      POWER_DOWN   <= (nxt_pwr == PWR_DOWN);
      SELF_REFRESH <= (nxt_pwr == PWR_SELF);
    end
  end
endmodule

// ===== ddrct_pkg.sv
// Shared constants and types of the DRAM command and timing block
package ddrct_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ROW_W  = 13;
  localparam int COL_W  = 10;
  localparam int BANK_W = 2;
  localparam int NBANK  = 4;
  localparam int BEAT_W = 8;
  localparam int PAIR_W = 2 * BEAT_W;
  localparam int ROW_KEEP = 4;
  localparam int MEM_AW = BANK_W + ROW_KEEP + 4;
  localparam int MEM_DEPTH = 1 << MEM_AW;

  // ----------------------------------------
  // Command codes {ras_n, cas_n, we_n}
  // ----------------------------------------
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // ----------------------------------------
  // Field positions and values
  // ----------------------------------------
  localparam int         AP_BIT    = 10;
  localparam int         BL_LSB    = 0;
  localparam int         BL_MSB    = 2;
  localparam logic [2:0] BL_CODE2  = 3'h1;
  localparam logic [2:0] BL_CODE4  = 3'h2;
  localparam logic [2:0] BL_CODE8  = 3'h3;
  localparam logic [3:0] BL_RESET  = 4'h4;

  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam int READ_LAT = 3;
  localparam int WCD_CYC  = 1;
  localparam int HIZ_CYC  = 3;

  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'b001,
    PWR_DOWN   = 3'b010,
    PWR_SELF   = 3'b100
  } ddrct_pwr_t;
endpackage

// ===== ddrct_burst_if.sv
// Carrier between the command logic and a burst sequencer
`timescale 1ns/10ps
interface ddrct_burst_if;
  import ddrct_pkg::*;
  logic                start;
  logic                stop;
  logic                ap_in;
  logic [BANK_W-1:0]   bank_in;
  logic [COL_W-1:0]    col_in;
  logic [3:0]          bl;
  logic                active;
  logic                fin;
  logic                ap;
  logic [BANK_W-1:0]   bank;
  logic [COL_W-1:0]    col;

  modport ctrl (output start, stop, ap_in, bank_in, col_in, bl,
                input  active, fin, ap, bank, col);
  modport eng  (input  start, stop, ap_in, bank_in, col_in, bl,
                output active, fin, ap, bank, col);
endinterface

// ===== ddrct_burst.sv
// Burst sequencer: walks column pairs of one read or write burst
`timescale 1ns/10ps
module ddrct_burst
  import ddrct_pkg::*;
(
  // Clock and reset
  input wire logic    clk,
  input wire logic    reset,
  // Command side
  ddrct_burst_if.eng  bus
);
  logic [3:0]       left_ff;
  logic [COL_W-1:0] mask;
  logic [COL_W-1:0] nxt_col;

  // Wrap the column within the burst-aligned block
  assign mask    = COL_W'(bus.bl) - COL_W'(1);
  assign nxt_col = (bus.col & ~mask) | ((bus.col + COL_W'(2)) & mask);
  assign bus.fin = bus.active & (left_ff == 4'h0) & ~bus.stop;

  always_ff @(posedge clk) begin
    if (reset) begin
      bus.active <= 1'b0;
    end else if (bus.start) begin
      bus.active <= 1'b1;
    end else if (bus.stop || bus.fin) begin
      bus.active <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      left_ff  <= 4'h0;
      bus.col  <= '0;
      bus.bank <= '0;
      bus.ap   <= 1'b0;
    end else if (bus.start) begin
      left_ff  <= (bus.bl >> 1) - 4'h1;
      bus.col  <= {bus.col_in[COL_W-1:1], 1'b0};
      bus.bank <= bus.bank_in;
      bus.ap   <= bus.ap_in;
    end else if (bus.active) begin
      left_ff  <= left_ff - 4'h1;
      bus.col  <= nxt_col;
    end
  end
endmodule

// ===== ddrct_top_assertions.sv
// Port checker of the DRAM command and timing block
`timescale 1ns/10ps
module ddrct_checker
  import ddrct_pkg::*;
(
  // Clock, reset and command pins
  input wire logic             CLK,
  input wire logic             RESET,
  input wire logic             CKE,
  input wire logic             CS_N,
  input wire logic             RAS_N,
  input wire logic             CAS_N,
  input wire logic             WE_N,
  input wire logic [ROW_W-1:0] A,
  // Device outputs
  input wire logic             DQ_OE,
  input wire logic             DQS_O,
  input wire logic             DQS_OE,
  input wire logic             POWER_DOWN,
  input wire logic             SELF_REFRESH
);
  logic       cke_ff;
  logic [2:0] cmd;
  logic       take;
  logic       rd_take;
  logic       ref_sel;
  assign cmd     = {RAS_N, CAS_N, WE_N};
  assign take    = !CS_N && CKE && cke_ff && !POWER_DOWN && !SELF_REFRESH;
  assign rd_take = take && cmd == CMD_RD;
  assign ref_sel = !CS_N && cmd == CMD_REF;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cke_ff <= 1'h1;
    end else begin
      cke_ff <= CKE;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_hiz;
    ##4 !DQ_OE;
  endsequence
  sequence s_sleep;
    $fell(CKE) && !POWER_DOWN && !SELF_REFRESH;
  endsequence
  a_rd_latency: assert property ($rose(DQ_OE) |-> $past(rd_take, 4))
    else $error("read data not four edges after a read");
  a_strobe_follow: assert property (DQS_OE == DQ_OE && DQS_O == DQ_OE)
    else $error("read strobe not aligned with read data");
  a_stop_hiz: assert property (take && cmd == CMD_BST |-> s_hiz)
    else $error("data driven after burst stop");
  a_pre_hiz: assert property (take && cmd == CMD_PRE && A[AP_BIT] |-> s_hiz)
    else $error("data driven after precharge");
  a_pd_entry: assert property (s_sleep ##0 !ref_sel |=> POWER_DOWN)
    else $error("power down not entered");
  a_sr_entry: assert property (s_sleep ##0 ref_sel |=> SELF_REFRESH)
    else $error("self refresh not entered");
  a_sleep_exit: assert property ($rose(CKE) |=> !POWER_DOWN && !SELF_REFRESH)
    else $error("low power state not left");
  a_sleep_hold: assert property (!CKE && !$past(CKE) |=> $stable({POWER_DOWN, SELF_REFRESH}))
    else $error("low power state changed while idle");
endmodule
bind ddrct_top ddrct_checker chk (.CLK(CLK), .RESET(RESET), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N),
  .CAS_N(CAS_N), .WE_N(WE_N), .A(A), .DQ_OE(DQ_OE), .DQS_O(DQS_O), .DQS_OE(DQS_OE),
  .POWER_DOWN(POWER_DOWN), .SELF_REFRESH(SELF_REFRESH));

// ===== ddrct_ctl_model.sv
// Controller model that issues commands and write data
`timescale 1ns/10ps
module ddrct_ctl_model
  import ddrct_pkg::*;
(
  // Clock
  input wire logic          clk,
  // Command and data pins
  output logic              cke,
  output logic              cs_n,
  output logic [2:0]        cmd,
  output logic [ROW_W-1:0]  a,
  output logic [BANK_W-1:0] ba,
  output logic [PAIR_W-1:0] dq,
  output logic              dqs,
  output logic [1:0]        dm
);
  logic cs_skip = 1'h0;
  initial begin
    {cke, cs_n, cmd, a, ba, dq, dqs, dm} = {2'h3, CMD_NOP, 34'h0};
  end
  task issue(input logic [2:0] c, input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] ad, input int gap);
    cmd <= c;
    cs_n <= cs_skip;
    ba <= b;
    a <= ad;
    @(posedge clk);
    // Gap zero leaves the pins to the next call, so no pin is driven twice at one edge
    if (gap > 0) begin
      cmd <= CMD_NOP;
      cs_n <= 1'h1;
      a <= ~ad;
      repeat (gap - 1) @(posedge clk);
    end
  endtask
  task wdata(input logic [2*PAIR_W-1:0] d, input logic [3:0] m);
    for (int i = 0; i < 2; i++) begin
      dq <= d[PAIR_W*i +: PAIR_W];
      dm <= m[2*i +: 2];
      dqs <= 1'h1;
      @(posedge clk);
    end
    dqs <= 1'h0;
    dq <= ~dq;
  endtask
  task cke_set(input logic v, input int n);
    cke <= v;
    repeat (n) @(posedge clk);
  endtask
endmodule

// ===== ddrct_top_tb_top.sv
// Self-checking bench of the DRAM command and timing block
`timescale 1ns/10ps
module ddrct_top_tb_top;
  import ddrct_pkg::*;
  logic              clk = 1'h0;
  logic              reset = 1'h1;
  logic              cke;
  logic              cs_n;
  logic              dqs;
  logic              dq_oe;
  logic              pd;
  logic              sr;
  logic [2:0]        cmd;
  logic [ROW_W-1:0]  a;
  logic [BANK_W-1:0] ba;
  logic [1:0]        dm;
  logic [PAIR_W-1:0] dq_i;
  logic [PAIR_W-1:0] dq_o;
  logic [PAIR_W-1:0] got_q[$];
  int                err_count = 0;
  int                checks_done = 0;
  int                cyc = 0;
  always #5 clk = ~clk;
  ddrct_ctl_model ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .cmd(cmd), .a(a), .ba(ba), .dq(dq_i), .dqs(dqs), .dm(dm));
  ddrct_top dut (.CLK(clk), .RESET(reset), .CKE(cke), .CS_N(cs_n), .RAS_N(cmd[2]), .CAS_N(cmd[1]), .WE_N(cmd[0]),
    .A(a), .BA(ba), .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE(dq_oe), .DQS_I(dqs), .DQS_O(), .DQS_OE(), .DM_I(dm),
    .POWER_DOWN(pd), .SELF_REFRESH(sr));
  task end_sim;
    $display("mismatches %0d of %0d checks", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task chk(input logic [PAIR_W-1:0] got, input logic [PAIR_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task st(input logic [1:0] e);
    @(negedge clk);
    chk(16'({pd, sr}), 16'(e));
    @(posedge clk);
  endtask
  task rd(input logic [1:0] b, input logic [ROW_W-1:0] c, input logic [2:0] cut, input int n);
    ctl.issue(CMD_RD, b, c, (cut !== CMD_NOP) ? 0 : 1);
    if (cut !== CMD_NOP) begin
      ctl.issue(cut, b, 13'h400, 1);
    end
    got_q = {};
    repeat (10) begin
      @(negedge clk);
      if (dq_oe === 1'h1) begin
        got_q.push_back(dq_o);
      end
      @(posedge clk);
    end
    chk(16'(got_q.size()), 16'(n));
  endtask
  task wr(input logic [1:0] b, input logic [ROW_W-1:0] c, input logic [31:0] d, input logic [3:0] m);
    fork
      ctl.issue(CMD_WR, b, c, 4 + 4 / 2);
      begin
        @(posedge clk);
        ctl.wdata(d, m);
      end
    join
  endtask
  task s_wr_rd;
    for (int b = 0; b < NBANK; b++) begin
      ctl.issue(CMD_ACT, 2'(b), 13'h5, 3);
      wr(2'(b), 13'h0, 32'h2222_1111 + b, 4'h0);
      wr(2'(b), 13'h0, 32'h4444_3333 + b, 4'h2);
      rd(2'(b), 13'h2, CMD_NOP, 2);
      chk(got_q[0], 16'h4444);
      chk(got_q[1], {8'h11, 8'h33 + 8'(b)});
    end
  endtask
  task s_bl_cut;
    ctl.issue(CMD_MRS, 2'h1, 13'(BL_CODE2), 2);
    rd(2'h1, 13'h0, CMD_NOP, 2);
    ctl.issue(CMD_MRS, 2'h0, 13'(BL_CODE8), 2);
    rd(2'h1, 13'h0, CMD_NOP, 4);
    rd(2'h1, 13'h0, CMD_BST, 1);
    rd(2'h1, 13'h0, CMD_PRE, 1);
    ctl.issue(CMD_MRS, 2'h0, 13'(BL_CODE2), 2);
    ctl.issue(CMD_ACT, 2'h1, 13'h5, 3);
    rd(2'h1, 13'h0, CMD_NOP, 1);
    ctl.issue(CMD_MRS, 2'h0, 13'(BL_CODE4), 2);
  endtask
  task s_ap_cs;
    ctl.issue(CMD_ACT, 2'h0, 13'h5, 3);
    ctl.issue(CMD_ACT, 2'h2, 13'h5, 3);
    ctl.issue(CMD_PRE, 2'h0, 13'h0, 3);
    rd(2'h2, 13'h0, CMD_NOP, 2);
    rd(2'h0, 13'h0, CMD_NOP, 0);
    ctl.cs_skip = 1'h1;
    rd(2'h2, 13'h0, CMD_NOP, 0);
    ctl.cs_skip = 1'h0;
    wr(2'h2, 13'h400, 32'h0, 4'h0);
    rd(2'h2, 13'h0, CMD_NOP, 0);
  endtask
  task s_power;
    ctl.cke_set(1'h0, 3);
    st(2'h2);
    ctl.cke_set(1'h1, 2);
    st(2'h0);
    fork
      ctl.cke_set(1'h0, 3);
      ctl.issue(CMD_REF, 2'h0, 13'h0, 1);
    join
    st(2'h1);
    ctl.cke_set(1'h1, 200);
    st(2'h0);
    ctl.issue(CMD_ACT, 2'h3, 13'h5, 3);
    rd(2'h3, 13'h0, CMD_NOP, 2);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'h0;
    s_wr_rd();
    s_bl_cut();
    s_ap_cs();
    s_power();
    end_sim();
  end
endmodule
